// >>> hw/dsd_pkg.sv
package dsd_pkg;
  // clock and stagger timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned STAGGER_S     = 12;
  localparam int unsigned STAGGER_CYC   = STAGGER_S * CLK_HZ;
  localparam int unsigned SETTLE_CYC    = 4;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_CMD       = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;
  localparam logic [11:0] OFS_STAGGER   = 12'h00C;

  // register select one-hot positions
  localparam int SEL_CTRL               = 0;
  localparam int SEL_CMD                = 1;
  localparam int SEL_STATUS             = 2;
  localparam int SEL_STAGGER            = 3;

  // field positions
  localparam int CTRL_MASTER_BIT        = 0;
  localparam int CTRL_IND_BIT           = 1;
  localparam int CMD_START_BIT          = 0;
  localparam int ST_ID_LSB              = 0;
  localparam int ST_WP_BIT              = 3;
  localparam int ST_PAR_BIT             = 4;
  localparam int ST_DELAY_BIT           = 5;
  localparam int ST_WAIT_BIT            = 6;
  localparam int ST_RUN_BIT             = 7;
  localparam int ST_VALID_BIT           = 8;
  localparam int ST_SYNC_BIT            = 9;

  // reset values
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

  typedef struct packed {
    logic       valid;
    logic       delay_start;
    logic       wait_cmd;
    logic       wp;
    logic       parity;
    logic [2:0] id;
  } dsd_straps_t;

  typedef enum logic [1:0] {
    DSD_SETTLE,
    DSD_STAGGER,
    DSD_HOLD,
    DSD_RUN
  } dsd_state_t;
endpackage

// >>> hw/dsd_top.sv
`timescale 1ns/100ps
`default_nettype none
module dsd_top
  import dsd_pkg::*;
#(
  parameter int unsigned STAGGER_CYCLES = STAGGER_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DELAY_START_STRAP,
  input  wire logic        WAIT_FOR_START_CMD_STRAP,
  input  wire logic        WRITE_PROTECT_STRAP,
  input  wire logic        PARITY_CHECK_STRAP,
  input  wire logic [2:0]  ID_HEADER_PRIMARY,
  input  wire logic [2:0]  ID_HEADER_SECONDARY,
  input  wire logic [2:0]  ID_COMBINED,
  input  wire logic        COMBINED_WAIT_STRAP,
  input  wire logic        COMBINED_DELAY_STRAP,
  input  wire logic        SYNC_INDEX_LINE_I,
  output logic             SYNC_INDEX_LINE_O,
  output logic             SYNC_INDEX_LINE_OE,
  input  wire logic        LOCAL_INDEX,
  output logic             SYNC_INDEX_IN,
  input  wire logic        START_UNIT,
  input  wire logic        WRITE_REQ,
  output logic             WRITE_ALLOW,
  output logic             WRITE_REFUSED,
  input  wire logic        PARITY_ERR,
  output logic             PARITY_CHECK_EN,
  output logic             PARITY_ERR_REPORT,
  input  wire logic        ACTIVITY,
  output logic             REMOTE_INDICATOR_SINK,
  output logic             SPINDLE_RUN,
  output logic      [2:0]  BUS_ID
);

  function automatic logic [3:0] dsd_sel(input logic [11:0] a);
    logic [3:0] s;
    s = 4'h0;
    case (a)
      OFS_CTRL:    s[SEL_CTRL] = 1'b1;
      OFS_CMD:     s[SEL_CMD] = 1'b1;
      OFS_STATUS:  s[SEL_STATUS] = 1'b1;
      OFS_STAGGER: s[SEL_STAGGER] = 1'b1;
      default:     s = 4'h0;
    endcase
    return s;
  endfunction

  // pin synchronisers
  logic [15:0] sync1;
  logic [15:0] sync2;
  wire  [15:0] raw = {SYNC_INDEX_LINE_I, COMBINED_DELAY_STRAP, COMBINED_WAIT_STRAP,
                      DELAY_START_STRAP, WAIT_FOR_START_CMD_STRAP, WRITE_PROTECT_STRAP,
                      PARITY_CHECK_STRAP, ID_COMBINED, ID_HEADER_SECONDARY,
                      ID_HEADER_PRIMARY};

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else if (CE) begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  dsd_state_t  state;
  dsd_state_t  next_state;
  dsd_straps_t straps;
  dsd_straps_t next_straps;
  logic [2:0]  settle;
  logic [2:0]  next_settle;
  logic [31:0] tick;
  logic [31:0] next_tick;
  logic [2:0]  units;
  logic [2:0]  next_units;
  logic [1:0]  ctrl;
  logic [1:0]  next_ctrl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        start_cmd;
  logic [3:0]  wsel;
  logic [3:0]  rsel;
  logic        commit;

  assign commit = PSEL && PENABLE && PREADY;
  assign wsel = dsd_sel(PADDR);
  assign rsel = dsd_sel(PADDR);
  assign start_cmd = START_UNIT || (commit && PWRITE && wsel[SEL_CMD] && PWDATA[CMD_START_BIT]);

  always_comb begin
    next_state = state;
    next_straps = straps;
    next_settle = settle;
    next_tick = tick;
    next_units = units;
    case (state)
      DSD_SETTLE: begin
        if (settle == 3'(SETTLE_CYC - 1)) begin
          next_straps.valid = 1'b1;
          next_straps.id = sync2[2:0] | sync2[5:3] | sync2[8:6];
          next_straps.parity = sync2[9];
          next_straps.wp = sync2[10];
          next_straps.wait_cmd = sync2[11] | sync2[13];
          next_straps.delay_start = sync2[12] | sync2[14];
          if (next_straps.wait_cmd) begin
            next_state = DSD_HOLD;
          end else if (next_straps.delay_start && (next_straps.id != 3'h0)) begin
            next_state = DSD_STAGGER;
            next_units = next_straps.id;
            next_tick = 32'h0000_0000;
          end else begin
            next_state = DSD_RUN;
          end
        end else begin
          next_settle = settle + 3'h1;
        end
      end
      DSD_STAGGER: begin
        if (tick == 32'(STAGGER_CYCLES - 1)) begin
          next_tick = 32'h0000_0000;
          next_units = units - 3'h1;
          if (units == 3'h1) begin
            next_state = DSD_RUN;
          end
        end else begin
          next_tick = tick + 32'h0000_0001;
        end
      end
      DSD_HOLD: begin
        if (start_cmd) begin
          next_state = DSD_RUN;
        end
      end
      DSD_RUN: next_state = DSD_RUN;
      default: next_state = DSD_SETTLE;
    endcase
  end

  always_comb begin
    next_ctrl = ctrl;
    next_pready = PSEL && PENABLE && !PREADY;
    next_prdata = PRDATA;
    next_pslverr = 1'b0;
    if (commit && PWRITE && wsel[SEL_CTRL]) begin
      next_ctrl = PWDATA[1:0];
    end
    if (next_pready) begin
      next_pslverr = (rsel == 4'h0);
      next_prdata = RDATA_RST;
      if (!PWRITE) begin
        if (rsel[SEL_CTRL]) begin
          next_prdata[1:0] = ctrl;
        end
        if (rsel[SEL_STATUS]) begin
          next_prdata[ST_ID_LSB +: 3] = straps.id;
          next_prdata[ST_WP_BIT] = straps.wp;
          next_prdata[ST_PAR_BIT] = straps.parity;
          next_prdata[ST_DELAY_BIT] = straps.delay_start;
          next_prdata[ST_WAIT_BIT] = straps.wait_cmd;
          next_prdata[ST_RUN_BIT] = SPINDLE_RUN;
          next_prdata[ST_VALID_BIT] = straps.valid;
          next_prdata[ST_SYNC_BIT] = SYNC_INDEX_IN;
        end
        if (rsel[SEL_STAGGER]) begin
          next_prdata[2:0] = units;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= DSD_SETTLE;
      straps <= '0;
      settle <= 3'h0;
      tick <= 32'h0000_0000;
      units <= 3'h0;
      ctrl <= CTRL_RST;
      PRDATA <= RDATA_RST;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      SPINDLE_RUN <= 1'b0;
      WRITE_ALLOW <= 1'b0;
      WRITE_REFUSED <= 1'b0;
      PARITY_CHECK_EN <= 1'b0;
      PARITY_ERR_REPORT <= 1'b0;
      REMOTE_INDICATOR_SINK <= 1'b0;
      SYNC_INDEX_LINE_O <= 1'b0;
      SYNC_INDEX_LINE_OE <= 1'b0;
      SYNC_INDEX_IN <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      straps <= next_straps;
      settle <= next_settle;
      tick <= next_tick;
      units <= next_units;
      ctrl <= next_ctrl;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      SPINDLE_RUN <= (next_state == DSD_RUN);
      WRITE_ALLOW <= next_straps.valid && !next_straps.wp;
      WRITE_REFUSED <= WRITE_REQ && !WRITE_ALLOW;
      PARITY_CHECK_EN <= next_straps.valid && next_straps.parity;
      PARITY_ERR_REPORT <= PARITY_ERR && PARITY_CHECK_EN;
      REMOTE_INDICATOR_SINK <= ACTIVITY || ctrl[CTRL_IND_BIT];
      SYNC_INDEX_LINE_OE <= ctrl[CTRL_MASTER_BIT];
      SYNC_INDEX_LINE_O <= ctrl[CTRL_MASTER_BIT] && LOCAL_INDEX;
      SYNC_INDEX_IN <= ctrl[CTRL_MASTER_BIT] ? LOCAL_INDEX : sync2[15];
    end
  end

  assign BUS_ID = straps.id;

  default clocking dsd_cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  AST_IMMEDIATE: assert property (
    $rose(straps.valid) && !straps.wait_cmd && !straps.delay_start |-> SPINDLE_RUN
  ) else $error("spindle did not start at once");

  AST_WAIT_WINS: assert property (
    $rose(straps.valid) && straps.wait_cmd |-> state == DSD_HOLD && !SPINDLE_RUN
  ) else $error("wait strap did not hold spindle");

  AST_HOLD_STOPPED: assert property (
    state == DSD_HOLD && !start_cmd |=> !SPINDLE_RUN
  ) else $error("spindle ran without start command");

  AST_HOLD_START: assert property (
    state == DSD_HOLD && start_cmd && CE |=> SPINDLE_RUN && state == DSD_RUN
  ) else $error("start command ignored");

  AST_STAGGER_LOAD: assert property (
    $rose(straps.valid) && straps.delay_start && !straps.wait_cmd |->
      (straps.id == 3'h0) ? SPINDLE_RUN : (units == straps.id && !SPINDLE_RUN)
  ) else $error("stagger not loaded from id");

  AST_STAGGER_STEP: assert property (
    state == DSD_STAGGER && CE && tick == 32'(STAGGER_CYCLES - 1) |=>
      units == $past(units) - 3'h1 && tick == 32'h0000_0000
  ) else $error("stagger step wrong");

  AST_WP: assert property (
    straps.valid && straps.wp |-> !WRITE_ALLOW ##1 (!$past(CE) || !WRITE_ALLOW)
  ) else $error("write allowed under protection");

  AST_PARITY: assert property (
    $rose(PARITY_ERR_REPORT) |-> $past(PARITY_ERR) && PARITY_CHECK_EN && straps.parity
  ) else $error("parity reported while disabled");

  AST_ID_SUM: assert property (
    $rose(straps.valid) |-> BUS_ID == ($past(sync2[2:0]) | $past(sync2[5:3]) | $past(sync2[8:6]))
  ) else $error("bus id not decoded");

  AST_STRAPS_HELD: assert property (
    straps.valid |=> $stable(straps)
  ) else $error("straps changed after sampling");

  AST_INDICATOR: assert property (
    $past(CE) && !$past(SYS_RST) |-> REMOTE_INDICATOR_SINK == $past(ACTIVITY || ctrl[CTRL_IND_BIT])
  ) else $error("indicator switch wrong");

  AST_SYNC_DIR: assert property (
    $past(CE) && !$past(SYS_RST) |-> SYNC_INDEX_LINE_OE == $past(ctrl[CTRL_MASTER_BIT])
  ) else $error("sync index direction wrong");

endmodule
`default_nettype wire

// >>> test/dsd_jumper_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsd_jumper_model (
  input  wire logic       fit_delay,
  input  wire logic       fit_wait,
  input  wire logic [2:0] id_val,
  input  wire logic       use_sec,
  input  wire logic       use_comb,
  input  wire logic       cable,
  input  wire logic       ext_index,
  input  wire logic       sync_o,
  input  wire logic       sync_oe,
  output logic            s_delay,
  output logic            s_wait,
  output logic            c_delay,
  output logic            c_wait,
  output logic      [2:0] id_pri,
  output logic      [2:0] id_sec,
  output logic      [2:0] id_comb,
  output logic            sync_i
);
  // id set on one place, except on both id_sec and id_comb when use_sec and use_comb are set
  assign id_pri  = (use_sec || use_comb) ? 3'h0 : id_val;
  assign id_sec  = use_sec ? id_val : 3'h0;
  assign id_comb = use_comb ? id_val : 3'h0;
  assign s_delay = use_comb ? 1'b0 : fit_delay;
  assign s_wait  = use_comb ? 1'b0 : fit_wait;
  assign c_delay = use_comb ? fit_delay : 1'b0;
  assign c_wait  = use_comb ? fit_wait : 1'b0;
  // no cable: the fitted jumper holds the line low
  assign sync_i  = sync_oe ? sync_o : (cable ? ext_index : 1'b0);
endmodule
`default_nettype wire

// >>> test/test_drive_option_strap_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module test_drive_option_strap_decoder;
  import dsd_pkg::*;
  logic        clock, sys_rst, psel, penable, pwrite, start_unit, write_req, parity_err;
  logic        activity, local_index, pready, pslverr, fit_delay, fit_wait, fit_wp, fit_par;
  logic        use_sec, use_comb, cable, ext_index, s_delay, s_wait, c_wait, c_delay;
  logic        sync_i, sync_o, sync_oe, sync_in, w_allow, w_ref, par_en, par_rep, ind, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  id_val, id_pri, id_sec, id_comb, bus_id;
  logic        err, ce;
  int          failures, checks;

  always #4 clock = ~clock;

  dsd_jumper_model u_jmp (.fit_delay(fit_delay), .fit_wait(fit_wait), .id_val(id_val),
    .use_sec(use_sec), .use_comb(use_comb), .cable(cable), .ext_index(ext_index),
    .sync_o(sync_o), .sync_oe(sync_oe), .s_delay(s_delay), .s_wait(s_wait),
    .c_delay(c_delay), .c_wait(c_wait), .id_pri(id_pri), .id_sec(id_sec),
    .id_comb(id_comb), .sync_i(sync_i));

  dsd_top #(.STAGGER_CYCLES(10)) u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DELAY_START_STRAP(s_delay),
    .WAIT_FOR_START_CMD_STRAP(s_wait), .WRITE_PROTECT_STRAP(fit_wp),
    .PARITY_CHECK_STRAP(fit_par), .ID_HEADER_PRIMARY(id_pri), .ID_HEADER_SECONDARY(id_sec),
    .ID_COMBINED(id_comb), .COMBINED_WAIT_STRAP(c_wait), .COMBINED_DELAY_STRAP(c_delay),
    .SYNC_INDEX_LINE_I(sync_i), .SYNC_INDEX_LINE_O(sync_o), .SYNC_INDEX_LINE_OE(sync_oe),
    .LOCAL_INDEX(local_index), .SYNC_INDEX_IN(sync_in), .START_UNIT(start_unit),
    .WRITE_REQ(write_req), .WRITE_ALLOW(w_allow), .WRITE_REFUSED(w_ref),
    .PARITY_ERR(parity_err), .PARITY_CHECK_EN(par_en), .PARITY_ERR_REPORT(par_rep),
    .ACTIVITY(activity), .REMOTE_INDICATOR_SINK(ind), .SPINDLE_RUN(run), .BUS_ID(bus_id));

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(input logic d, w, p, q, input logic [2:0] id, input logic sec, comb);
    @(posedge clock);
    fit_delay <= d;
    fit_wait <= w;
    fit_wp <= p;
    fit_par <= q;
    id_val <= id;
    use_sec <= sec;
    use_comb <= comb;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clock);
    #1;
  endtask

  task automatic pulses(input logic ref_e, input logic rep_e);
    @(posedge clock);
    write_req <= 1'b1;
    parity_err <= 1'b1;
    @(posedge clock);
    write_req <= 1'b0;
    parity_err <= 1'b0;
    #1;
    chk("write_refused", 32'(ref_e), 32'(w_ref));
    chk("parity_report", 32'(rep_e), 32'(par_rep));
  endtask

  task automatic t_immediate;
    boot(0, 0, 0, 0, 3'h5, 0, 0);
    chk("run", 32'h1, 32'(run));
    chk("bus_id", 32'h5, 32'(bus_id));
    chk("write_allow", 32'h1, 32'(w_allow));
    chk("parity_en", 32'h0, 32'(par_en));
    pulses(1'b0, 1'b0);
    @(posedge clock);
    id_val <= 3'h2;
    fit_wp <= 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk("bus_id", 32'h5, 32'(bus_id));
    chk("write_allow", 32'h1, 32'(w_allow));
  endtask

  task automatic t_wait;
    boot(0, 1, 0, 0, 3'h1, 1, 0);
    chk("bus_id", 32'h1, 32'(bus_id));
    repeat (40) @(posedge clock);
    #1;
    chk("run", 32'h0, 32'(run));
    @(posedge clock);
    ce <= 1'b0;
    start_unit <= 1'b1;
    @(posedge clock);
    start_unit <= 1'b0;
    @(posedge clock);
    ce <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("run_frozen", 32'h0, 32'(run));
    @(posedge clock);
    start_unit <= 1'b1;
    @(posedge clock);
    start_unit <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("run", 32'h1, 32'(run));
  endtask

  task automatic t_delay;
    boot(1, 0, 0, 0, 3'h0, 0, 0);
    chk("run", 32'h1, 32'(run));
    boot(1, 0, 0, 0, 3'h2, 0, 1);
    @(posedge clock);
    start_unit <= 1'b1;
    @(posedge clock);
    start_unit <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("run", 32'h0, 32'(run));
    apb(1'b0, OFS_STAGGER, 32'h0);
    chk("stagger", 32'h1, rd);
    @(posedge clock);
    #1;
    chk("run", 32'h0, 32'(run));
    @(posedge clock);
    #1;
    chk("run", 32'h1, 32'(run));
  endtask

  task automatic t_both;
    boot(1, 1, 0, 0, 3'h3, 0, 1);
    repeat (60) @(posedge clock);
    #1;
    chk("run", 32'h0, 32'(run));
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (3) @(posedge clock);
    #1;
    chk("run", 32'h1, 32'(run));
  endtask

  task automatic t_protect;
    boot(0, 0, 1, 1, 3'h6, 0, 0);
    chk("write_allow", 32'h0, 32'(w_allow));
    chk("parity_en", 32'h1, 32'(par_en));
    pulses(1'b1, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h6 | (32'h1 << ST_WP_BIT) | (32'h1 << ST_PAR_BIT) | (32'h1 << ST_RUN_BIT)
      | (32'h1 << ST_VALID_BIT), rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("rdata", 32'h0, rd);
    apb(1'b1, OFS_CTRL, 32'h3);
    local_index <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("sync_oe", 32'h1, 32'(sync_oe));
    chk("sync_o", 32'h1, 32'(sync_o));
    chk("sync_in", 32'h1, 32'(sync_in));
    chk("indicator", 32'h1, 32'(ind));
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'b1, OFS_CTRL, 32'h0);
    activity <= 1'b1;
    cable <= 1'b1;
    ext_index <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("sync_oe", 32'h0, 32'(sync_oe));
    chk("sync_o", 32'h0, 32'(sync_o));
    chk("indicator", 32'h1, 32'(ind));
    @(posedge clock);
    activity <= 1'b0;
    ext_index <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("indicator", 32'h0, 32'(ind));
    chk("sync_in", 32'h0, 32'(sync_in));
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    give_verdict();
  end

  initial begin
    {clock, psel, penable, pwrite, start_unit, write_req, parity_err, activity} = 8'h00;
    {local_index, fit_delay, fit_wait, fit_wp, fit_par, use_sec, use_comb, cable} = 8'h00;
    {ext_index, paddr, pwdata, id_val} = 48'h0;
    sys_rst = 1'b1;
    ce = 1'b1;
    t_immediate();
    t_wait();
    t_delay();
    t_both();
    t_protect();
    give_verdict();
  end
endmodule
`default_nettype wire
